/* rtl/peer_cfg_device.sv */
// Device end: decodes port and modem string configuration packets
// Functional notes
// [R01] Selector 3 decodes words 1-3 as port
// [R02] Station 0-31, default 2
// [R03] Highest polled 1-31, default 31
// [R04] Timeout from word 3, max 12750 ms
// [R05] Pass-through flag forwards diagnostics to host
// [R06] Rate codes 0-5 table, 6-7 19200
// [R07] Other stations use the same rate
// [R08] Defaults first; committed settings restored at power-up
// [R09] String starts empty; selector 4 loads 1-14
// [R10] Characters after first NUL are ignored
// [R11] Terminator implied after fourteenth character
// [R12] Host sends selector 5 only after 4
// [R13] Terminator implied after twenty-eighth character
// [R14] Upper byte odd char, lower byte even
// [R15] Host write dir 0 mode 1; read dir 1; host forces mode 1 only on string writes, port writes take i_mode
// [R16] Header bits 15 mode 14 strobe 13 dir 12 reset
// [R17] Word 1: highest polled upper, station lower
// [R18] Packets taken only on handshake strobe
`timescale 1ns/1ps
module peer_cfg_device
  import peer_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // Power events and battery
  input  wire logic        i_power_up,    // Pulse: supply has returned
  input  wire logic        i_batt_ok,     // Level: backup storage intact
  // Diagnostic commands from the peer network
  input  wire logic        i_diag_valid,  // Pulse: command received
  // Host image words
  peer_cfg_if.dev          img,
  // Applied port settings
  output logic [4:0]       o_station,
  output logic [4:0]       o_max_station,
  output logic [15:0]      o_timeout_ms,
  output logic             o_pass_thru,
  output logic [2:0]       o_rate_code,
  output logic [14:0]      o_rate_bps,
  // Modem initialisation string
  output logic [27:0][7:0] o_init_str,
  output logic [4:0]       o_init_len,
  // Diagnostic routing
  output logic             o_diag_exec,
  output logic             o_diag_fwd
);

  // Whole device state
  typedef struct packed {
    logic             strobe_q;   // Strobe seen last cycle
    logic             mode_q;     // Mode bit seen last cycle
    port_cfg_type     work;       // Settings in use
    port_cfg_type     store;      // Battery-backed committed copy
    logic             store_ok;   // Committed copy is meaningful
    logic             str1_done;  // First string packet taken
    logic [7:0][15:0] resp;       // Input image to the host
    logic             diag_exec;  // Command run locally
    logic             diag_fwd;   // Command sent on to host
  } dev_state_type;

  localparam dev_state_type ST_RST = '{
    strobe_q:  1'b0,
    mode_q:    1'b0,
    work:      CFG_DEF,
    store:     CFG_DEF,
    store_ok:  1'b0,
    str1_done: 1'b0,
    resp:      '0,
    diag_exec: 1'b0,
    diag_fwd:  1'b0
  };

  dev_state_type s_reg;   // Registered state
  dev_state_type s_next;  // Next state

  // Rate code to bit/s; codes 6 and 7 share the top rate
  function automatic logic [14:0] rate_bps(input logic [2:0] code);
    case (code)
      3'h0:    rate_bps = BPS_300;
      3'h1:    rate_bps = BPS_600;
      3'h2:    rate_bps = BPS_1200;
      3'h3:    rate_bps = BPS_2400;
      3'h4:    rate_bps = BPS_4800;
      3'h5:    rate_bps = BPS_9600;
      default: rate_bps = BPS_19200;  // [R06]
    endcase
  endfunction : rate_bps

  // Index of the first NUL, or full length when none
  function automatic logic [4:0] str_len(input logic [27:0][7:0] s);
    logic [4:0] n;
    n = 5'(STR_CHARS);  // Terminator implied past the end [R13]
    for (int i = STR_CHARS - 1; i >= 0; i--) begin
      if (s[i] == 8'h00) begin
        n = 5'(i);
      end
    end
    str_len = n;
  endfunction : str_len

  // Zero every character from the first NUL onward
  function automatic logic [27:0][7:0] str_mask(
    input logic [27:0][7:0] s
  );
    logic [4:0] n;
    n = str_len(s);
    str_mask = s;
    for (int i = 0; i < STR_CHARS; i++) begin
      if (5'(i) >= n) begin
        str_mask[i] = 8'h00;  // [R10]
      end
    end
  endfunction : str_mask

  // Header fields, split once for readability
  logic [15:0] hdr;
  logic        hdr_mode;
  logic        hdr_strb;
  logic        hdr_dir;
  logic        hdr_rst;
  logic [2:0]  hdr_sel;
  logic        take;  // Strobe rising edge

  always_comb begin
    hdr      = img.out_image[0];
    hdr_mode = hdr[HDR_MODE_BIT];        // [R16]
    hdr_strb = hdr[HDR_STRB_BIT];        // [R16]
    hdr_dir  = hdr[HDR_DIR_BIT];         // [R16]
    hdr_rst  = hdr[HDR_RST_BIT];         // [R16]
    hdr_sel  = hdr[HDR_SEL_MSB:0];       // [R16]
    take     = hdr_strb && !s_reg.strobe_q;  // [R18]
  end

  // Next-state logic
  always_comb begin
    logic [4:0]  w_sta;
    logic [4:0]  w_max;
    logic [15:0] w_tmo;
    int          base;
    w_sta  = img.out_image[1][4:0];                    // [R17]
    w_max  = img.out_image[1][W1_MAX_LSB +: 5];        // [R17]
    w_tmo  = img.out_image[3];                         // [R04]
    base   = 0;
    s_next = s_reg;
    s_next.strobe_q  = hdr_strb;
    s_next.mode_q    = hdr_mode;
    s_next.diag_exec = 1'b0;
    s_next.diag_fwd  = 1'b0;

    // Handshake echo: strobe returned while host holds it
    s_next.resp[0] = {hdr[15:12] & {1'b1, hdr_strb, 2'b11},
                      hdr[11:0]};

    // Leaving configuration mode commits the settings
    if (s_reg.mode_q && !hdr_mode) begin
      s_next.store    = s_reg.work;  // [R08]
      s_next.store_ok = 1'b1;        // [R08]
    end

    // Power-up: restore committed copy unless the battery failed
    if (i_power_up) begin
      if (i_batt_ok && s_reg.store_ok) begin
        s_next.work = s_reg.store;   // [R08]
      end else begin
        s_next.work     = CFG_DEF;   // [R08]
        s_next.store_ok = 1'b0;
      end
      s_next.str1_done = 1'b0;
    end else if (take && hdr_rst) begin
      // Reset bit drops uncommitted edits
      s_next.work = s_reg.store_ok ? s_reg.store : CFG_DEF;
    end else if (take && !hdr_dir && hdr_mode) begin
      // Write packets, only in configuration mode
      case (hdr_sel)
        SEL_PORT: begin  // [R01]
          s_next.work.station = w_sta;  // [R02]
          // Out-of-range values leave the old setting
          if (w_max >= MAX_STA_MIN) begin
            s_next.work.max_station = w_max;  // [R03]
          end
          if (w_tmo >= TMO_MS_MIN && w_tmo <= TMO_MS_MAX) begin
            s_next.work.timeout_ms = w_tmo;  // [R04]
          end
          s_next.work.pass_thru = img.out_image[2][W2_PASS_BIT];  // [R05]
          s_next.work.rate_code = img.out_image[2][2:0];  // [R06]
        end
        SEL_STR1: begin
          for (int w = 1; w < IMG_WORDS; w++) begin
            s_next.work.init_str[2*w-2] = img.out_image[w][15:8]; // [R14]
            s_next.work.init_str[2*w-1] = img.out_image[w][7:0];  // [R14]
          end
          // Upper half cleared: a full first half ends there
          for (int i = STR_HALF; i < STR_CHARS; i++) begin
            s_next.work.init_str[i] = 8'h00;  // [R11]
          end
          s_next.str1_done = 1'b1;  // [R09]
        end
        SEL_STR2: begin
          // Ignored until the first half has been loaded
          if (s_reg.str1_done) begin  // [R12]
            for (int w = 1; w < IMG_WORDS; w++) begin
              s_next.work.init_str[STR_HALF+2*w-2] =
                img.out_image[w][15:8];  // [R14]
              s_next.work.init_str[STR_HALF+2*w-1] =
                img.out_image[w][7:0];   // [R14]
            end
          end
        end
        default: begin
          // Other selectors belong to other blocks
        end
      endcase
    end else if (take && hdr_dir) begin
      // Read back: either mode accepted [R15]
      case (hdr_sel)
        SEL_PORT: begin
          s_next.resp[1] = {3'b000, s_reg.work.max_station,
                            3'b000, s_reg.work.station};  // [R17]
          s_next.resp[2] = {12'h000, s_reg.work.pass_thru,
                            s_reg.work.rate_code};
          s_next.resp[3] = s_reg.work.timeout_ms;
        end
        SEL_STR1, SEL_STR2: begin
          base = (hdr_sel == SEL_STR2) ? STR_HALF : 0;
          for (int w = 1; w < IMG_WORDS; w++) begin
            s_next.resp[w] = {o_init_str[base+2*w-2],
                              o_init_str[base+2*w-1]};  // [R14]
          end
        end
        default: begin
          // Nothing to return
        end
      endcase
    end

    // Diagnostic routing follows the applied flag
    if (i_diag_valid) begin
      s_next.diag_exec = !s_reg.work.pass_thru;  // [R05]
      s_next.diag_fwd  = s_reg.work.pass_thru;   // [R05]
    end
  end

  // State register; reset means first power-up, so defaults
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= ST_RST;  // [R08] [R09]
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state; peers must match this rate [R07]
  always_comb begin
    o_station     = s_reg.work.station;
    o_max_station = s_reg.work.max_station;
    o_timeout_ms  = s_reg.work.timeout_ms;
    o_pass_thru   = s_reg.work.pass_thru;
    o_rate_code   = s_reg.work.rate_code;
    o_rate_bps    = rate_bps(s_reg.work.rate_code);  // [R06]
    o_init_str    = str_mask(s_reg.work.init_str);   // [R10]
    o_init_len    = str_len(s_reg.work.init_str);    // [R10]
    o_diag_exec   = s_reg.diag_exec;
    o_diag_fwd    = s_reg.diag_fwd;
    img.in_image  = s_reg.resp;
  end

endmodule : peer_cfg_device

/* rtl/peer_cfg_pkg.sv */
// Shared constants and types for the peer port configuration packets
package peer_cfg_pkg;

  // Image geometry
  localparam int IMG_WORDS    = 8;     // Words per packet image
  localparam int STR_CHARS    = 28;    // Modem string capacity
  localparam int STR_HALF     = 14;    // Characters per string packet

  // Header word 0 field positions
  localparam int HDR_MODE_BIT = 15;    // Configuration mode when set
  localparam int HDR_STRB_BIT = 14;    // Handshake strobe
  localparam int HDR_DIR_BIT  = 13;    // 1 = read back, 0 = write
  localparam int HDR_RST_BIT  = 12;    // Module settings reset
  localparam int HDR_SEL_MSB  = 2;     // Selector field top bit

  // Packet selector codes
  localparam logic [2:0] SEL_PORT = 3'h3;  // Peer port setup
  localparam logic [2:0] SEL_STR1 = 3'h4;  // String chars 1..14
  localparam logic [2:0] SEL_STR2 = 3'h5;  // String chars 15..28

  // Port word layout
  localparam int W1_MAX_LSB   = 8;     // Highest polled in upper byte
  localparam int W2_PASS_BIT  = 3;     // Diagnostic pass-through flag

  // Ranges and defaults
  localparam logic [4:0]  STATION_DEF  = 5'h02;
  localparam logic [4:0]  MAX_STA_MIN  = 5'h01;
  localparam logic [4:0]  MAX_STA_DEF  = 5'h1f;
  localparam logic [15:0] TMO_MS_MIN   = 16'h0064;  // 100 ms
  localparam logic [15:0] TMO_MS_MAX   = 16'h31ce;  // 12,750 ms
  localparam logic [15:0] TMO_MS_DEF   = 16'h2710;  // 10,000 ms
  localparam logic [2:0]  RATE_DEF     = 3'h6;      // 19200 bit/s
  localparam logic        PASS_DEF     = 1'b0;

  // Rate table, bit/s
  localparam logic [14:0] BPS_300   = 15'h012c;
  localparam logic [14:0] BPS_600   = 15'h0258;
  localparam logic [14:0] BPS_1200  = 15'h04b0;
  localparam logic [14:0] BPS_2400  = 15'h0960;
  localparam logic [14:0] BPS_4800  = 15'h12c0;
  localparam logic [14:0] BPS_9600  = 15'h2580;
  localparam logic [14:0] BPS_19200 = 15'h4b00;

  // Settings that survive power cycles while the battery holds
  typedef struct packed {
    logic [4:0]            station;
    logic [4:0]            max_station;
    logic [15:0]           timeout_ms;
    logic                  pass_thru;
    logic [2:0]            rate_code;
    logic [27:0][7:0]      init_str;
  } port_cfg_type;

  localparam port_cfg_type CFG_DEF = '{
    station:     STATION_DEF,
    max_station: MAX_STA_DEF,
    timeout_ms:  TMO_MS_DEF,
    pass_thru:   PASS_DEF,
    rate_code:   RATE_DEF,
    init_str:    '0
  };

endpackage : peer_cfg_pkg

/* rtl/peer_cfg_if.sv */
// Output and input image words between host controller and device
`timescale 1ns/1ps
interface peer_cfg_if;
  logic [7:0][15:0] out_image;  // Host writes, device reads
  logic [7:0][15:0] in_image;   // Device writes, host reads

  modport host (output out_image, input in_image);
  modport dev  (input out_image, output in_image);
endinterface : peer_cfg_if

/* rtl/peer_cfg_host.sv */
// Host end: builds packets in the output image and runs the strobe
`timescale 1ns/1ps
module peer_cfg_host
  import peer_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // Request from user logic
  input  wire logic        i_req,       // Pulse: send one packet
  input  wire logic [2:0]  i_selector,  // Packet selector
  input  wire logic        i_read,      // 1 = read back
  input  wire logic        i_mode,      // Mode bit for all packets except string writes
  input  wire logic        i_mod_rst,   // Module reset bit
  input  wire logic [6:0][15:0] i_words, // Words 1..7, word 1 at [0]
  // Answer to user logic
  output logic             o_busy,
  output logic             o_done,      // Pulse: packet acknowledged
  output logic             o_refused,   // Pulse: request not sent
  output logic [6:0][15:0] o_rd_words,  // Returned words 1..7
  // Device image words
  peer_cfg_if.host         img
);

  // Handshake phases
  typedef enum logic [1:0] {
    H_IDLE,     // Waiting for a request
    H_WAIT_ACK, // Strobe high, waiting for echo
    H_WAIT_CLR  // Strobe low, waiting for echo to drop
  } host_fsm_type;

  // Whole host state
  typedef struct packed {
    host_fsm_type     fsm;
    logic [7:0][15:0] image;     // Output image driven to device
    logic             str1_sent; // First string packet delivered
    logic             done;
    logic             refused;
    logic [6:0][15:0] rd_words;
  } host_state_type;

  host_state_type h_reg;   // Registered state
  host_state_type h_next;  // Next state

  logic echo;  // Device's copy of the strobe
  assign echo = img.in_image[0][HDR_STRB_BIT];

  // Next-state logic
  always_comb begin
    logic str_pkt;
    str_pkt = (i_selector == SEL_STR1) || (i_selector == SEL_STR2);
    h_next         = h_reg;
    h_next.done    = 1'b0;
    h_next.refused = 1'b0;
    case (h_reg.fsm)
      H_IDLE: begin
        if (i_req) begin
          // Second half only after the first [R12]
          if (i_selector == SEL_STR2 && !i_read && !h_reg.str1_sent) begin
            h_next.refused = 1'b1;  // [R12]
          end else begin
            h_next.image[0] = '0;
            h_next.image[0][HDR_SEL_MSB:0] = i_selector;  // [R16]
            h_next.image[0][HDR_DIR_BIT]   = i_read;      // [R15]
            // String write forces configuration mode
            h_next.image[0][HDR_MODE_BIT]  =
              (str_pkt && !i_read) ? 1'b1 : i_mode;       // [R15]
            h_next.image[0][HDR_RST_BIT]   = i_mod_rst;   // [R16]
            h_next.image[0][HDR_STRB_BIT]  = 1'b1;        // [R18]
            // Words carry the rate every station must share [R07]
            for (int w = 1; w < IMG_WORDS; w++) begin
              h_next.image[w] = i_read ? 16'h0000 : i_words[w-1]; // [R17]
            end
            h_next.fsm = H_WAIT_ACK;
          end
        end
      end
      H_WAIT_ACK: begin
        if (echo) begin
          for (int w = 1; w < IMG_WORDS; w++) begin
            h_next.rd_words[w-1] = img.in_image[w];
          end
          h_next.image[0][HDR_STRB_BIT] = 1'b0;
          if (h_reg.image[0][HDR_SEL_MSB:0] == SEL_STR1 &&
              !h_reg.image[0][HDR_DIR_BIT]) begin
            h_next.str1_sent = 1'b1;  // [R12]
          end
          h_next.fsm = H_WAIT_CLR;
        end
      end
      H_WAIT_CLR: begin
        if (!echo) begin
          h_next.done = 1'b1;
          h_next.fsm  = H_IDLE;
        end
      end
      default: begin
        h_next.fsm = H_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      h_reg <= '{fsm: H_IDLE, default: '0};
    end else begin
      h_reg <= h_next;
    end
  end

  // Outputs from state
  always_comb begin
    img.out_image = h_reg.image;
    o_busy        = (h_reg.fsm != H_IDLE);
    o_done        = h_reg.done;
    o_refused     = h_reg.refused;
    o_rd_words    = h_reg.rd_words;
  end

endmodule : peer_cfg_host

/* test/peer_cfg_checker.sv */
// Concurrent checks on the image link and the device outputs
`timescale 1ns/1ps
module peer_cfg_checker
  import peer_cfg_pkg::*;
(
  // Clock and reset
  input wire logic             i_ref_clk,
  input wire logic             i_rst_n,
  // Device stimulus
  input wire logic             i_power_up,
  input wire logic             i_diag_valid,
  // Image words
  input wire logic [7:0][15:0] out_image,
  input wire logic [7:0][15:0] in_image,
  // Device outputs
  input wire logic [4:0]       o_station,
  input wire logic [4:0]       o_max_station,
  input wire logic [15:0]      o_timeout_ms,
  input wire logic             o_pass_thru,
  input wire logic [2:0]       o_rate_code,
  input wire logic [14:0]      o_rate_bps,
  input wire logic [27:0][7:0] o_init_str,
  input wire logic [4:0]       o_init_len,
  input wire logic             o_diag_exec,
  input wire logic             o_diag_fwd
);
  logic       strb_reg;  // Strobe level at the last edge
  logic       tk;        // Write packet accepted at this edge
  logic [2:0] sel;       // Selector of the current header
  logic       ok_max;    // Polling limit is not zero
  logic       ok_tmo;    // Timeout inside its range

  // Remember the strobe so a held level is not a new packet
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strb_reg <= 1'b0;
    end else begin
      strb_reg <= out_image[0][HDR_STRB_BIT];
    end
  end

  // Power return wins over a packet, so it is left out here
  assign tk = out_image[0][HDR_STRB_BIT] & !strb_reg & !i_power_up
      & out_image[0][HDR_MODE_BIT] & !out_image[0][HDR_DIR_BIT]
      & !out_image[0][HDR_RST_BIT];
  assign sel = out_image[0][HDR_SEL_MSB:0];
  assign ok_max = out_image[1][12:8] != 5'h00;
  assign ok_tmo = out_image[3] >= TMO_MS_MIN && out_image[3] <= TMO_MS_MAX;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_echo_header: assert property (
    in_image[0] == $past(out_image[0])) else $error("header echo wrong");
  a_station_take: assert property (
    tk && sel == SEL_PORT |=> o_station == $past(out_image[1][4:0]))
    else $error("station not applied");
  a_max_take: assert property (
    tk && sel == SEL_PORT |=> o_max_station == ($past(ok_max) ?
      $past(out_image[1][12:8]) : $past(o_max_station)))
    else $error("polling limit wrong");
  a_tmo_take: assert property (
    tk && sel == SEL_PORT |=> o_timeout_ms == ($past(ok_tmo) ?
      $past(out_image[3]) : $past(o_timeout_ms)))
    else $error("timeout wrong");
  a_rate_top: assert property (
    (o_rate_code[2:1] == 2'b11) == (o_rate_bps == BPS_19200))
    else $error("rate decode wrong");
  a_diag_route: assert property (
    i_diag_valid |=> o_diag_exec != $past(o_pass_thru)
      && o_diag_fwd == $past(o_pass_thru))
    else $error("diagnostic routed wrong");
  a_strobe_held: assert property (
    out_image[0][HDR_STRB_BIT] && strb_reg && !i_power_up
      |=> $stable(o_station) && $stable(o_init_len))
    else $error("held strobe retaken");
  a_first_half: assert property (
    tk && sel == SEL_STR1 |=> o_init_len <= 5'h0e
      && o_init_str[27:14] == '0) else $error("first half wrong");
  a_nul_end: assert property (
    o_init_len == 5'h1c || o_init_str[o_init_len] == 8'h00)
    else $error("string end wrong");
endmodule : peer_cfg_checker

/* test/tb_peer_port_config_packets.sv */
// Self-checking bench joining the host and device ends
`timescale 1ns/1ps
module tb_peer_port_config_packets;
  import peer_cfg_pkg::*;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t mismatch %h %h", $time, a, b); end end

  // Clock, reset and device stimulus
  logic             i_ref_clk = 1'b0;
  logic             i_rst_n = 1'b0;
  logic             i_power_up = 1'b0;
  logic             i_batt_ok = 1'b1;
  logic             i_diag_valid = 1'b0;
  // Host user side
  logic             i_req = 1'b0;
  logic [2:0]       i_selector = 3'h0;
  logic             i_read = 1'b0;
  logic             i_mode = 1'b1;
  logic             i_mod_rst = 1'b0;
  logic [6:0][15:0] i_words = '0;
  logic             o_busy, o_done, o_refused;
  logic [6:0][15:0] o_rd_words;
  // Device outputs
  logic [4:0]       o_station, o_max_station, o_init_len;
  logic [15:0]      o_timeout_ms;
  logic             o_pass_thru, o_diag_exec, o_diag_fwd;
  logic [2:0]       o_rate_code;
  logic [14:0]      o_rate_bps;
  logic [27:0][7:0] o_init_str;
  // Verdict counters
  int               fails = 0;
  int               checks = 0;
  logic             refused_seen;  // Last request was turned down

  always #20 i_ref_clk = ~i_ref_clk;

  peer_cfg_if img_if ();
  peer_cfg_host peer_cfg_host_inst (.i_ref_clk, .i_rst_n, .i_req,
    .i_selector, .i_read, .i_mode, .i_mod_rst, .i_words, .o_busy,
    .o_done, .o_refused, .o_rd_words, .img(img_if.host));
  peer_cfg_device peer_cfg_device_inst (.i_ref_clk, .i_rst_n,
    .i_power_up, .i_batt_ok, .i_diag_valid, .img(img_if.dev), .o_station,
    .o_max_station, .o_timeout_ms, .o_pass_thru, .o_rate_code,
    .o_rate_bps, .o_init_str, .o_init_len, .o_diag_exec, .o_diag_fwd);
  peer_cfg_checker peer_cfg_checker_inst (.i_ref_clk, .i_rst_n,
    .i_power_up, .i_diag_valid, .out_image(img_if.out_image),
    .in_image(img_if.in_image), .o_station, .o_max_station,
    .o_timeout_ms, .o_pass_thru, .o_rate_code, .o_rate_bps, .o_init_str,
    .o_init_len, .o_diag_exec, .o_diag_fwd);

  // Print the verdict and stop
  task automatic give_verdict();
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // One packet through the host; a silent device ends the run
  task automatic send(input logic [2:0] sel, input logic rd,
      input logic md, input logic rs, input logic [6:0][15:0] wd);
    int n;
    @(negedge i_ref_clk);
    i_selector = sel;
    i_read = rd;
    i_mode = md;
    i_mod_rst = rs;
    i_words = wd;
    i_req = 1'b1;
    @(negedge i_ref_clk);
    i_req = 1'b0;
    `CHK(o_busy, !o_refused)
    for (n = 0; n < 40 && o_done !== 1'b1 && o_refused !== 1'b1; n++) begin
      @(negedge i_ref_clk);
    end
    refused_seen = o_refused;
    `CHK(o_busy, 1'b0)
    if (n == 40) begin
      fails++;
      give_verdict();
    end
  endtask : send

  // Port packet: word 1 limit and station, word 2 flag and rate
  task automatic port(input logic [4:0] sta, input logic [4:0] mx,
      input logic ps, input logic [2:0] rt, input logic [15:0] tm,
      input logic md);
    send(SEL_PORT, 1'b0, md, 1'b0,
      {64'h0, tm, 12'h000, ps, rt, 3'h0, mx, 3'h0, sta});
  endtask : port

  // Applied settings against expectation
  task automatic chk_port(input logic [4:0] sta, input logic [4:0] mx,
      input logic [15:0] tm, input logic ps, input logic [2:0] rt);
    `CHK(o_station, sta)
    `CHK(o_max_station, mx)
    `CHK(o_timeout_ms, tm)
    `CHK(o_pass_thru, ps)
    `CHK(o_rate_code, rt)
  endtask : chk_port

  // Diagnostic arrival and the route it takes
  task automatic diag(input logic ex, input logic fw);
    @(negedge i_ref_clk);
    i_diag_valid = 1'b1;
    @(negedge i_ref_clk);
    i_diag_valid = 1'b0;
    `CHK({o_diag_exec, o_diag_fwd}, {ex, fw})
  endtask : diag

  // Supply return with or without backup storage
  task automatic power(input logic b);
    @(negedge i_ref_clk);
    i_batt_ok = b;
    i_power_up = 1'b1;
    @(negedge i_ref_clk);
    i_power_up = 1'b0;
    @(negedge i_ref_clk);
  endtask : power

  // Fourteen characters, first one in the upper byte of word 1
  function automatic logic [6:0][15:0] pack(input logic [111:0] s);
    for (int w = 0; w < 7; w++) begin
      pack[w] = s[111-16*w -: 16];
    end
  endfunction : pack

  // Expected bit rate of a code
  function automatic logic [14:0] bps(input logic [2:0] c);
    case (c)
      3'h0: return BPS_300;
      3'h1: return BPS_600;
      3'h2: return BPS_1200;
      3'h3: return BPS_2400;
      3'h4: return BPS_4800;
      3'h5: return BPS_9600;
      default: return BPS_19200;
    endcase
  endfunction : bps

  initial begin
    logic [111:0] s1, s2;
    s1 = "ATDT5551234567";
    s2 = "ATH0S7=60&K3~~";
    repeat (3) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    chk_port(5'h02, 5'h1f, 16'h2710, 1'b0, 3'h6);
    `CHK(o_init_len, 5'h00)
    send(SEL_STR2, 1'b0, 1'b1, 1'b0, pack(s2));
    `CHK(refused_seen, 1'b1)
    // Every rate code, station following the loop count
    for (int k = 0; k < 8; k++) begin
      port(5'(k), 5'h05, 1'b0, 3'(k), 16'h01f4, 1'b1);
      `CHK(o_rate_bps, bps(3'(k)))
      `CHK(o_station, 5'(k))
      `CHK(img_if.out_image[2][2:0], 3'(k))
    end
    // Range edges, then out-of-range values kept back
    port(5'h1f, 5'h01, 1'b1, 3'h5, 16'h31ce, 1'b1);
    chk_port(5'h1f, 5'h01, 16'h31ce, 1'b1, 3'h5);
    diag(1'b0, 1'b1);
    port(5'h00, 5'h00, 1'b1, 3'h5, 16'h31cf, 1'b1);
    chk_port(5'h00, 5'h01, 16'h31ce, 1'b1, 3'h5);
    port(5'h00, 5'h01, 1'b0, 3'h5, 16'h0063, 1'b1);
    `CHK(o_timeout_ms, 16'h31ce)
    port(5'h00, 5'h01, 1'b0, 3'h5, 16'h0064, 1'b1);
    `CHK(o_timeout_ms, 16'h0064)
    diag(1'b1, 1'b0);
    // Run-mode packet is ignored but commits the settings
    port(5'h09, 5'h03, 1'b0, 3'h1, 16'h0100, 1'b0);
    `CHK(o_station, 5'h00)
    port(5'h0c, 5'h03, 1'b0, 3'h1, 16'h0100, 1'b1);
    power(1'b1);
    chk_port(5'h00, 5'h01, 16'h0064, 1'b0, 3'h5);
    port(5'h0c, 5'h03, 1'b0, 3'h1, 16'h0100, 1'b1);
    send(SEL_PORT, 1'b0, 1'b1, 1'b1, '0);
    `CHK(o_station, 5'h00)
    power(1'b0);
    chk_port(5'h02, 5'h1f, 16'h2710, 1'b0, 3'h6);
    // Port settings read back in run mode
    send(SEL_PORT, 1'b1, 1'b0, 1'b0, '0);
    `CHK(o_rd_words[2:0], 48'h2710_0006_1f02)
    // Full first half, full second half, read back
    send(SEL_STR1, 1'b0, 1'b1, 1'b0, pack(s1));
    `CHK(o_init_len, 5'h0e)
    send(SEL_STR2, 1'b0, 1'b1, 1'b0, pack(s2));
    `CHK(o_init_len, 5'h1c)
    for (int k = 0; k < 14; k++) begin
      `CHK(o_init_str[k], s1[111-8*k -: 8])
      `CHK(o_init_str[k+14], s2[111-8*k -: 8])
    end
    send(SEL_STR1, 1'b1, 1'b0, 1'b0, '0);
    `CHK(o_rd_words, pack(s1))
    send(SEL_STR2, 1'b1, 1'b0, 1'b0, '0);
    `CHK(o_rd_words, pack(s2))
    // Early terminator hides the rest; host forces configuration mode
    s1 = {"ATZ", 8'h00, "XXXXXXXXXX"};
    send(SEL_STR1, 1'b0, 1'b0, 1'b0, pack(s1));
    `CHK(o_init_len, 5'h03)
    `CHK(o_init_str[27:3], 200'h0)
    give_verdict();
  end
endmodule : tb_peer_port_config_packets
